// ### rtl/counter_event_debug_irq_control.sv
// debug halt, event routing and interrupt enable control of the timer unit
//
// Behaviour
// - A module soft reset clears every register except the debug run bit.
// - With debug run 0 the counter stops during debug halt, with 1 it keeps running.
// - Each channel's match/capture event is passed out only while its output enable is set.
// - The wrap event is passed out only while the wrap output enable is set.
// - Incoming events are ignored unless the event input enable is 1.
// - The invert bit inverts the incoming event source before use.
// - Action 0 does nothing, 1 retriggers, 2 counts once per event, 3 starts.
// - Action 5 captures period into capture zero and pulse width into capture one.
// - Action 6 captures period into capture one and pulse width into capture zero.
// - Event routing control ignores writes while the counter is enabled.
// - Writing 1 to a channel bit of enable-clear clears that channel's enable, 0 does nothing.
// - Writing 1 to the sync bit of enable-clear disables the sync-done interrupt.
// - Enable-clear and enable-set read back the same shared enable bits.
// - Writing 1 to the error bit of enable-clear disables the error interrupt.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tc_event_regs.svh"

module counter_event_debug_irq_control
	import tc_event_pkg::*;
(
	input wire logic clock, // 25 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic hsel, // AHB-Lite slave select
	input wire logic [31:0] haddr, // AHB-Lite address
	input wire logic [1:0] htrans, // AHB-Lite transfer type
	input wire logic hwrite, // AHB-Lite write
	input wire logic [2:0] hsize, // AHB-Lite size, word only
	input wire logic [31:0] hwdata, // AHB-Lite write data
	input wire logic hready, // AHB-Lite bus ready
	output logic hreadyout, // AHB-Lite slave ready
	output logic hresp, // AHB-Lite response, always OKAY
	output logic [31:0] hrdata, // AHB-Lite read data
	input wire logic debugHaltIn, // processor held in debug halt, async
	input wire logic eventIn, // incoming event, async
	input wire logic [1:0] chanMatchIn, // per-channel match/capture pulse
	input wire logic wrapIn, // counter overflow/underflow pulse
	input wire logic errorIn, // error pulse from the core
	input wire logic syncDoneIn, // synchronisation ready pulse
	output logic counterRun, // counter may advance
	output logic [1:0] chanEventOut, // routed channel events
	output logic wrapEventOut, // routed wrap event
	output action_pulse_t actionOut, // event actions to the core
	output logic irq // level interrupt
);

	ctrl_state_t s, n;
	logic accept;
	logic [5:0] addrIdx;
	logic [7:0] readClear;
	logic [7:0] events;

	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	event_action_decode decode (
		.clock(clock),
		.rst_n(rst_n),
		.evLevel(s.evSync[1]),
		.event_input_enable(s.event_routing_control[`EV_INPUT_EN_BIT]),
		.event_input_invert(s.event_routing_control[`EV_INVERT_BIT]),
		.input_action_select(s.event_routing_control[`EV_ACTION_MSB:`EV_ACTION_LSB]),
		.actionOut(actionOut)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		accept = hsel && htrans[1] && hready;
		addrIdx = (haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0) ? haddr[7:2]
			: `IDX_UNMAPPED;
		readClear = 8'h00;
		events = 8'h00;

		// only the second flop of each pair is read by logic
		n.evSync = {s.evSync[0], eventIn};
		n.haltSync = {s.haltSync[0], debugHaltIn};

		// data phase of a write
		if (s.wrPend) begin
			unique case (s.wrIdx)
				`IDX_CONTROL: begin
					// soft reset wins over the rest of the same write
					if (hwdata[`CTRL_SOFT_RESET_BIT]) begin
						n.enable = 1'b0;
						n.event_routing_control = `RST_EVENT_ROUTING_CONTROL;
						n.intEn = `RST_INTERRUPT_ENABLE;
						n.status = 8'h00;
					end else begin
						n.enable = hwdata[`CTRL_ENABLE_BIT];
					end
				end
				`IDX_DEBUG_HALT_BEHAVIOUR: n.run_during_debug_halt = hwdata[`DBG_RUN_BIT];
				`IDX_EVENT_ROUTING_CONTROL: begin
					if (!s.enable) begin
						n.event_routing_control = hwdata[15:0] & `EV_WRITE_MASK;
					end
				end
				`IDX_INTERRUPT_ENABLE_CLEAR: begin
					n.intEn = s.intEn & ~(hwdata[7:0] & `INT_WRITE_MASK);
				end
				`IDX_INTERRUPT_ENABLE_SET: begin
					n.intEn = s.intEn | (hwdata[7:0] & `INT_WRITE_MASK);
				end
				default: n = n;
			endcase
		end

		// address phase
		n.wrPend = accept && hwrite;
		n.wrIdx = addrIdx;
		n.rdata = 32'h00000000;
		if (accept && !hwrite) begin
			// read data reflects a write finishing in this same cycle
			unique case (addrIdx)
				`IDX_CONTROL: n.rdata[`CTRL_ENABLE_BIT] = n.enable;
				`IDX_DEBUG_HALT_BEHAVIOUR: n.rdata[`DBG_RUN_BIT] = n.run_during_debug_halt;
				`IDX_EVENT_ROUTING_CONTROL: n.rdata[15:0] = n.event_routing_control;
				`IDX_INTERRUPT_ENABLE_CLEAR: n.rdata[7:0] = n.intEn;
				`IDX_INTERRUPT_ENABLE_SET: n.rdata[7:0] = n.intEn;
				`IDX_INTERRUPT_STATUS: begin
					n.rdata[7:0] = n.status;
					readClear = n.status;
				end
				default: n.rdata = 32'h00000000;
			endcase
		end

		// sticky status; a new event in the clearing cycle survives
		events[`INT_WRAP_BIT] = wrapIn;
		events[`INT_ERR_BIT] = errorIn;
		events[`INT_SYNC_BIT] = syncDoneIn;
		events[`INT_CHAN0_BIT] = chanMatchIn[0];
		events[`INT_CHAN1_BIT] = chanMatchIn[1];
		n.status = (n.status & ~readClear) | events;

		n.hready = 1'b1;
		n.irq = |(n.status & n.intEn);
		n.run = n.enable && (n.run_during_debug_halt || !s.haltSync[1]);
		n.chanEv = chanMatchIn & {n.event_routing_control[`EV_CHAN1_OUT_BIT], n.event_routing_control[`EV_CHAN0_OUT_BIT]};
		n.wrapEv = wrapIn & n.event_routing_control[`EV_WRAP_OUT_BIT];
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.run_during_debug_halt <= `RST_DEBUG_HALT_BEHAVIOUR;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = s.hready;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign counterRun = s.run;
	assign chanEventOut = s.chanEv;
	assign wrapEventOut = s.wrapEv;
	assign irq = s.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_dbg_keep: assert property ((s.wrPend && s.wrIdx == 6'h00 && hwdata[0])
		|=> (s.run_during_debug_halt == $past(s.run_during_debug_halt)) && s.event_routing_control == 16'h0000 && !s.enable)
		else $error("soft reset disturbed debug run or missed a register");
	a_run_halted: assert property ((s.enable && !s.run_during_debug_halt && s.haltSync[1]
		&& !(s.wrPend && (s.wrIdx == 6'h00 || s.wrIdx == 6'h08))) |=> !counterRun)
		else $error("counter runs during debug halt");
	a_run_debug: assert property ((s.enable && s.run_during_debug_halt
		&& !(s.wrPend && (s.wrIdx == 6'h00 || s.wrIdx == 6'h08))) |=> counterRun)
		else $error("counter stopped although debug run is set");
	a_chan_event: assert property ((chanMatchIn[0] && s.event_routing_control[12] && !s.wrPend)
		|=> chanEventOut[0])
		else $error("channel zero event not routed");
	a_chan_block: assert property ((!s.event_routing_control[13] && !s.wrPend) |=> !chanEventOut[1])
		else $error("channel one event routed while disabled");
	a_wrap_event: assert property ((!s.wrPend) |=> wrapEventOut
		== ($past(wrapIn) && $past(s.event_routing_control[8])))
		else $error("wrap event routing wrong");
	a_event_routing_control_protect: assert property ((s.wrPend && s.wrIdx == 6'h0A && s.enable)
		|=> $stable(s.event_routing_control))
		else $error("event control changed while enabled");
	a_chan_clear: assert property ((s.wrPend && s.wrIdx == 6'h0C && hwdata[4])
		|=> !s.intEn[4])
		else $error("channel enable not cleared");
	a_clear_bits: assert property ((s.wrPend && s.wrIdx == 6'h0C)
		|=> (s.intEn & ($past(hwdata[7:0]) & 8'h3B)) == 8'h00
		&& (s.intEn | ($past(hwdata[7:0]) & 8'h3B)) == ($past(s.intEn) | ($past(hwdata[7:0]) & 8'h3B)))
		else $error("enable clear wrong: ones must clear, zeros must keep");
	a_err_clr: assert property ((s.wrPend && s.wrIdx == 6'h0C && hwdata[1]) |=> !s.intEn[1])
		else $error("error enable not cleared");
	a_wrap_clr: assert property ((s.wrPend && s.wrIdx == 6'h0C && hwdata[0]) |=> !s.intEn[0])
		else $error("wrap enable not cleared");
	a_shared_read: assert property ((hsel && htrans[1] && hready && !hwrite && !s.wrPend
		&& haddr == 32'h00000034) |=> hrdata[7:0] == $past(s.intEn))
		else $error("enable set readback differs from shared enables");
	a_irq_level: assert property ((wrapIn && s.intEn[`INT_WRAP_BIT] && !s.wrPend) |=> irq)
		else $error("enabled wrap event did not raise the interrupt");

endmodule // counter_event_debug_irq_control
`default_nettype wire

// ### rtl/tc_event_regs.svh
// register offsets, field positions, reset values for the event/debug/irq control block
`ifndef TC_EVENT_REGS_SVH
`define TC_EVENT_REGS_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL 6'h00
`define IDX_DEBUG_HALT_BEHAVIOUR 6'h08
`define IDX_EVENT_ROUTING_CONTROL 6'h0A
`define IDX_INTERRUPT_ENABLE_CLEAR 6'h0C
`define IDX_INTERRUPT_ENABLE_SET 6'h0D
`define IDX_INTERRUPT_STATUS 6'h0E
`define IDX_UNMAPPED 6'h3F

// control register fields
`define CTRL_SOFT_RESET_BIT 0
`define CTRL_ENABLE_BIT 1

// debug register fields
`define DBG_RUN_BIT 0

// event routing control fields
`define EV_ACTION_LSB 0
`define EV_ACTION_MSB 2
`define EV_INVERT_BIT 4
`define EV_INPUT_EN_BIT 5
`define EV_WRAP_OUT_BIT 8
`define EV_CHAN0_OUT_BIT 12
`define EV_CHAN1_OUT_BIT 13
`define EV_WRITE_MASK 16'h3137

// interrupt enable / status fields
`define INT_WRAP_BIT 0
`define INT_ERR_BIT 1
`define INT_SYNC_BIT 3
`define INT_CHAN0_BIT 4
`define INT_CHAN1_BIT 5
`define INT_WRITE_MASK 8'h3B

// reset values
`define RST_DEBUG_HALT_BEHAVIOUR 1'h0
`define RST_EVENT_ROUTING_CONTROL 16'h0000
`define RST_INTERRUPT_ENABLE 8'h00

`endif

// ### rtl/tc_event_pkg.sv
// types shared by the event/debug/irq control block
package tc_event_pkg;

	typedef enum logic [2:0] {
		ACT_OFF = 3'h0,
		ACT_RETRIGGER = 3'h1,
		ACT_COUNT = 3'h2,
		ACT_START = 3'h3,
		ACT_RESERVED4 = 3'h4,
		ACT_PERIOD_THEN_WIDTH = 3'h5,
		ACT_WIDTH_THEN_PERIOD = 3'h6,
		ACT_RESERVED7 = 3'h7
	} input_action_t;

	// pulses sent to the counting core
	typedef struct packed {
		logic retrigger;
		logic countStep;
		logic start;
		logic captureZero;
		logic captureOne;
	} action_pulse_t;

	typedef struct packed {
		logic prevLevel;
		action_pulse_t pulse;
	} decode_state_t;

	typedef struct packed {
		logic [1:0] evSync;
		logic [1:0] haltSync;
		logic enable;
		logic run_during_debug_halt;
		logic [15:0] event_routing_control;
		logic [7:0] intEn;
		logic [7:0] status;
		logic wrPend;
		logic [5:0] wrIdx;
		logic [31:0] rdata;
		logic hready;
		logic irq;
		logic run;
		logic [1:0] chanEv;
		logic wrapEv;
	} ctrl_state_t;

endpackage

// ### rtl/event_action_decode.sv
// decodes the incoming event into counter actions
`timescale 1ns/1ns
`default_nettype none
`include "tc_event_regs.svh"

module event_action_decode
	import tc_event_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic evLevel, // synchronised event level
	input wire logic event_input_enable, // accept incoming events
	input wire logic event_input_invert, // invert event source
	input wire logic [2:0] input_action_select, // action code
	output action_pulse_t actionOut // registered action pulses
);

	decode_state_t s, n;
	logic level;
	logic rise;
	logic fall;

	always_comb begin
		n = s;
		level = evLevel ^ event_input_invert;
		rise = level & ~s.prevLevel;
		fall = ~level & s.prevLevel;
		n.prevLevel = level;
		n.pulse = '0;
		if (event_input_enable) begin
			unique case (input_action_t'(input_action_select))
				ACT_RETRIGGER: n.pulse.retrigger = rise;
				ACT_COUNT: n.pulse.countStep = rise;
				ACT_START: n.pulse.start = rise;
				ACT_PERIOD_THEN_WIDTH: begin
					n.pulse.captureZero = rise;
					n.pulse.retrigger = rise;
					n.pulse.captureOne = fall;
				end
				ACT_WIDTH_THEN_PERIOD: begin
					n.pulse.captureOne = rise;
					n.pulse.retrigger = rise;
					n.pulse.captureZero = fall;
				end
				default: n.pulse = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign actionOut = s.pulse;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_input_ignored: assert property (!event_input_enable |=> actionOut == '0)
		else $error("action pulse while event input disabled");
	a_count_step: assert property ((event_input_enable && input_action_select == 3'h2
		&& (evLevel ^ event_input_invert) && !s.prevLevel) |=> actionOut.countStep)
		else $error("count step missing on event");
	a_reserved_idle: assert property ((input_action_select == 3'h4
		|| input_action_select == 3'h7) |=> actionOut == '0)
		else $error("reserved action produced a pulse");
	a_width_capture: assert property ((event_input_enable && input_action_select == 3'h5
		&& !(evLevel ^ event_input_invert) && s.prevLevel) |=> actionOut.captureOne)
		else $error("width not captured into register one");
	a_width_capture_b: assert property ((event_input_enable && input_action_select == 3'h6
		&& !(evLevel ^ event_input_invert) && s.prevLevel) |=> actionOut.captureZero)
		else $error("width not captured into register zero");

endmodule // event_action_decode
`default_nettype wire

// ### verif/core_event_model.sv
// bench model of the counting core and event system around the control block
`timescale 1ns/1ns
`default_nettype none

module core_event_model (
	input wire logic clock, // system clock
	output logic debugHaltIn, // processor halted by debugger
	output logic eventIn, // asynchronous event source level
	output logic [1:0] chanMatchIn, // channel match/capture pulses
	output logic wrapIn, // overflow/underflow pulse
	output logic errorIn, // error pulse
	output logic syncDoneIn // sync ready pulse
);
	initial begin
		debugHaltIn = 1'b0;
		eventIn = 1'b0;
		{chanMatchIn, wrapIn, errorIn, syncDoneIn} = 5'h00;
	end

	// order {chan1, chan0, wrap, error, sync}; every pulse lasts one cycle
	task automatic pulse(input logic [4:0] p);
		@(posedge clock);
		{chanMatchIn, wrapIn, errorIn, syncDoneIn} <= p;
		@(posedge clock);
		{chanMatchIn, wrapIn, errorIn, syncDoneIn} <= 5'h00;
	endtask

	task automatic level(input logic halt, input logic ev);
		@(posedge clock);
		debugHaltIn <= halt;
		eventIn <= ev;
	endtask
endmodule // core_event_model
`default_nettype wire

// ### verif/tb_top.sv
// register-level testbench of the event, debug and interrupt control block
`timescale 1ns/1ns
`default_nettype none
`include "tc_event_regs.svh"

module tb_top;
	import tc_event_pkg::*;
	localparam logic [7:0] A_CTL = {`IDX_CONTROL, 2'b00};
	localparam logic [7:0] A_DBG = {`IDX_DEBUG_HALT_BEHAVIOUR, 2'b00};
	localparam logic [7:0] A_EV = {`IDX_EVENT_ROUTING_CONTROL, 2'b00};
	localparam logic [7:0] A_CLR = {`IDX_INTERRUPT_ENABLE_CLEAR, 2'b00};
	localparam logic [7:0] A_SET = {`IDX_INTERRUPT_ENABLE_SET, 2'b00};
	localparam logic [7:0] A_STAT = {`IDX_INTERRUPT_STATUS, 2'b00};
	localparam logic [7:0] A_BAD = {`IDX_UNMAPPED, 2'b00};
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout, hresp, irq, counterRun, wrapEventOut, debugHaltIn, eventIn;
	logic wrapIn, errorIn, syncDoneIn;
	logic [1:0] chanMatchIn, chanEventOut;
	logic [31:0] hrdata;
	action_pulse_t actionOut;
	int nErrors = 0;
	int testsRun = 0;
	logic [4:0] rise [8] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h00, 5'h12, 5'h11, 5'h00};
	logic [4:0] fall [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h01, 5'h02, 5'h00};
	logic [7:0] clrW [6] = '{8'h00, 8'h10, 8'h20, 8'h08, 8'h02, 8'h01};
	logic [7:0] clrE [6] = '{8'h3B, 8'h2B, 8'h0B, 8'h03, 8'h01, 8'h00};

	always #20 clock = ~clock;

	counter_event_debug_irq_control DUT (.clock(clock), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.debugHaltIn(debugHaltIn), .eventIn(eventIn), .chanMatchIn(chanMatchIn),
		.wrapIn(wrapIn), .errorIn(errorIn), .syncDoneIn(syncDoneIn), .counterRun(counterRun),
		.chanEventOut(chanEventOut), .wrapEventOut(wrapEventOut), .actionOut(actionOut),
		.irq(irq));

	core_event_model core (.clock(clock), .debugHaltIn(debugHaltIn), .eventIn(eventIn),
		.chanMatchIn(chanMatchIn), .wrapIn(wrapIn), .errorIn(errorIn), .syncDoneIn(syncDoneIn));

	// ----------------------------------------
	// compares and closing
	// ----------------------------------------
	task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_act(input logic [4:0] exp, input action_pulse_t got);
		testsRun++;
		if (got !== action_pulse_t'(exp)) begin
			nErrors++;
			$display("[FAIL] actionOut expected %h seen %h", exp, got);
		end
	endtask

	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	// every wait is bounded; a slave that never answers is counted as a mismatch
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		chk_word("hresp", 32'h0, {31'h0, hresp});
		if (n >= 50) chk_word("bus wait", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk_word($sformatf("reg %h", a), exp, x);
	endtask

	task automatic act(input logic ev, input logic [4:0] exp);
		action_pulse_t seen;
		seen = '0;
		core.level(1'b0, ev);
		repeat (8) begin
			@(posedge clock);
			#1 seen = seen | actionOut;
		end
		chk_act(exp, seen);
	endtask

	initial begin
		#400000;
		nErrors++;
		wrapUp();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		rchk(A_DBG, 32'h0);
		rchk(A_EV, 32'h0);
		rchk(A_CLR, 32'h0);
		wr(A_BAD, 32'hFFFFFFFF);
		rchk(A_BAD, 32'h0);
		$display("test reset values done");
		wr(A_EV, 32'h00003100);
		core.pulse(5'h1C);
		#1 chk_word("chanEventOut", 32'h3, {30'h0, chanEventOut});
		chk_word("wrapEventOut", 32'h1, {31'h0, wrapEventOut});
		wr(A_EV, 32'h00001000);
		core.pulse(5'h1C);
		#1 chk_word("chanEventOut", 32'h1, {30'h0, chanEventOut});
		chk_word("wrapEventOut", 32'h0, {31'h0, wrapEventOut});
		$display("test event outputs done");
		wr(A_SET, 32'h3B);
		rchk(A_STAT, 32'h31);
		core.pulse(5'h1F);
		#1 chk_word("irq", 32'h1, {31'h0, irq});
		rchk(A_STAT, 32'h3B);
		@(posedge clock);
		#1 chk_word("irq", 32'h0, {31'h0, irq});
		for (int i = 0; i < 6; i++) begin
			wr(A_CLR, {24'h0, clrW[i]});
			rchk(A_SET, {24'h0, clrE[i]});
		end
		wr(A_SET, 32'h10);
		rchk(A_CLR, 32'h10);
		core.pulse(5'h04);
		#1 chk_word("irq", 32'h0, {31'h0, irq});
		core.pulse(5'h08);
		#1 chk_word("irq", 32'h1, {31'h0, irq});
		rchk(A_STAT, 32'h11);
		$display("test interrupts done");
		for (int c = 0; c < 8; c++) begin
			wr(A_EV, 32'h20 | 32'(c));
			act(1'b1, rise[c]);
			act(1'b0, fall[c]);
		end
		wr(A_EV, 32'h02);
		act(1'b1, 5'h00);
		act(1'b0, 5'h00);
		wr(A_EV, 32'h32);
		repeat (8) @(posedge clock);
		act(1'b1, 5'h00);
		act(1'b0, 5'h08);
		$display("test event actions done");
		wr(A_DBG, 32'h0);
		core.level(1'b1, 1'b0);
		wr(A_CTL, 32'h2);
		repeat (5) @(posedge clock);
		#1 chk_word("counterRun", 32'h0, {31'h0, counterRun});
		wr(A_EV, 32'h25);
		rchk(A_EV, 32'h32);
		wr(A_CTL, 32'h0);
		wr(A_DBG, 32'h1);
		wr(A_CTL, 32'h2);
		repeat (5) @(posedge clock);
		#1 chk_word("counterRun", 32'h1, {31'h0, counterRun});
		wr(A_CTL, 32'h1);
		rchk(A_DBG, 32'h1);
		rchk(A_EV, 32'h0);
		rchk(A_SET, 32'h0);
		#1 chk_word("counterRun", 32'h0, {31'h0, counterRun});
		$display("test debug and soft reset done");
		wrapUp();
	end
endmodule // tb_top
`default_nettype wire
